// >>> boot_cfg_pkg.sv
// Functional notes
// - the boot device is 8 bits wide when the width strap is 0, 16 when 1.
// - reset mode 0 holds the reset output low at least 4096 cycles; 1 is reserved.
// - the 3-bit pci mode strap selects off, satellite, host or reserved operation.
// - the pci enable bit starts at 1 for satellite codes, 0 for all others.
// - a watchdog-disable strap of 1 leaves the watchdog off after cold reset.
// - the pipeline clock select is taken at cold reset and never changes after.
// - the internal bus clock is the pipeline clock divided by two, always.
package boot_cfg_pkg;

  // strap vector layout
  localparam int unsigned STRAP_W = 16;
  localparam int unsigned PCLK_SEL_LSB = 0;
  localparam int unsigned PCLK_SEL_MSB = 2;
  localparam int unsigned BOOT_WIDTH_BIT = 7;
  localparam int unsigned RESET_MODE_BIT = 8;
  localparam int unsigned PCI_MODE_LSB = 9;
  localparam int unsigned PCI_MODE_MSB = 11;
  localparam int unsigned WDT_DIS_BIT = 12;
  localparam int unsigned RSVD_LSB = 13;
  localparam int unsigned RSVD_MSB = 15;

  // pci mode codes
  typedef enum logic [2:0] {
    PCI_OFF = 3'b000,
    PCI_SAT_NOT_READY = 3'b001,
    PCI_SAT_SUSPEND = 3'b010,
    PCI_HOST_EXT_ARB = 3'b011,
    PCI_HOST_FIXED_ARB = 3'b100,
    PCI_HOST_RR_ARB = 3'b101,
    PCI_RSVD6 = 3'b110,
    PCI_RSVD7 = 3'b111
  } pci_mode_e;

  // timing: reset output length and bus clock ratio
  localparam int unsigned RST_OUT_CYCLES = 4096;
  localparam int unsigned BUS_CLK_DIV = 2;

  // register map (byte addresses) and fields
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] CTRL_OFS = 4'h8;
  localparam int unsigned ST_RST_DONE_BIT = 0;
  localparam int unsigned ST_RSVD_STRAP_BIT = 1;
  localparam int unsigned ST_RSVD_RMODE_BIT = 2;
  localparam int unsigned ST_RSVD_PCI_BIT = 3;
  localparam int unsigned CTRL_PCI_EN_BIT = 0;
  localparam int unsigned CTRL_WDT_EN_BIT = 1;

endpackage : boot_cfg_pkg

// >>> boot_config_loader.sv
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module boot_config_loader #(
  parameter int unsigned RST_OUT_CYCLES = boot_cfg_pkg::RST_OUT_CYCLES
) (
  // clock and cold reset
  input wire logic core_clk_i,
  input wire logic reset_output_n_i,
  // strapped configuration vector
  input wire logic [15:0] memory_data_bus_i,
  // avalon-mm slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // decoded configuration
  output logic reset_output_n_o,
  output logic boot_width_16_o,
  output logic [2:0] pci_mode_o,
  output logic pci_host_o,
  output logic pci_satellite_o,
  output logic pci_enable_o,
  output logic watchdog_enable_o,
  output logic [2:0] pclk_select_o,
  output logic internal_bus_clock_o
);

  localparam int unsigned CNT_W = $clog2(RST_OUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RST_OUT_CYCLES - 1);

  // satellite codes pull the pci enable bit high at boot
  function automatic logic is_sat(input logic [2:0] m);
    is_sat = (m == boot_cfg_pkg::PCI_SAT_NOT_READY) ||
             (m == boot_cfg_pkg::PCI_SAT_SUSPEND);
  endfunction : is_sat

  function automatic logic is_host(input logic [2:0] m);
    is_host = (m == boot_cfg_pkg::PCI_HOST_EXT_ARB) ||
              (m == boot_cfg_pkg::PCI_HOST_FIXED_ARB) ||
              (m == boot_cfg_pkg::PCI_HOST_RR_ARB);
  endfunction : is_host

  logic captured_reg;
  logic [15:0] cfg_reg;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic rst_out_n_reg;
  logic host_reg;
  logic sat_reg;
  logic pci_en_reg;
  logic wdt_en_reg;
  logic bus_clk_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;

  // strap decode of the live bus, used only at capture
  wire capture = !captured_reg;
  wire [2:0] mode_in =
    memory_data_bus_i[boot_cfg_pkg::PCI_MODE_MSB:boot_cfg_pkg::PCI_MODE_LSB];
  // clock select as strapped, only looked at by the checks
  wire [2:0] pclk_in =
    memory_data_bus_i[boot_cfg_pkg::PCLK_SEL_MSB:boot_cfg_pkg::PCLK_SEL_LSB];
  wire [2:0] mode_q =
    cfg_reg[boot_cfg_pkg::PCI_MODE_MSB:boot_cfg_pkg::PCI_MODE_LSB];
  wire rsvd_strap =
    |cfg_reg[boot_cfg_pkg::RSVD_MSB:boot_cfg_pkg::RSVD_LSB];
  wire rsvd_rmode = cfg_reg[boot_cfg_pkg::RESET_MODE_BIT];
  wire rsvd_pci = (mode_q == boot_cfg_pkg::PCI_RSVD6) ||
                  (mode_q == boot_cfg_pkg::PCI_RSVD7);

  // bus decode: a request is answered one cycle after it shows up
  wire req = read_i || write_i;
  wire accept = req && wait_reg;
  wire commit = req && !wait_reg;
  wire sel_cfg = (address_i == boot_cfg_pkg::CFG_OFS);
  wire sel_st = (address_i == boot_cfg_pkg::STATUS_OFS);
  wire sel_ctrl = (address_i == boot_cfg_pkg::CTRL_OFS);
  wire ctrl_wr = commit && write_i && sel_ctrl && byteenable_i[0];
  wire [31:0] cfg_word = {16'h0000, cfg_reg};
  wire [31:0] st_word = {28'h0000000, rsvd_pci, rsvd_rmode, rsvd_strap,
                         rst_out_n_reg};
  wire [31:0] ctrl_word = {30'h00000000, wdt_en_reg, pci_en_reg};
  // unmapped addresses read as zero so software never sees junk
  wire [31:0] rd_mux = sel_cfg ? cfg_word :
                       sel_st ? st_word :
                       sel_ctrl ? ctrl_word : 32'h00000000;

  // latch straps
  // capture on the first edge after release, then freeze until next reset
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      captured_reg <= 1'b0;
      cfg_reg <= 16'h0000;
      host_reg <= 1'b0;
      sat_reg <= 1'b0;
    end else if (capture) begin
      captured_reg <= 1'b1;
      cfg_reg <= memory_data_bus_i;
      host_reg <= is_host(mode_in);
      sat_reg <= is_sat(mode_in);
    end
  end

  // reset output length
  // reserved reset mode is treated as normal rather than left undefined
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      rst_cnt_reg <= '0;
      rst_out_n_reg <= 1'b0;
    end else if (captured_reg && !rst_out_n_reg) begin
      rst_cnt_reg <= rst_cnt_reg + CNT_W'(1);
      if (rst_cnt_reg == CNT_LAST) begin
        rst_out_n_reg <= 1'b1;
      end
    end
  end

  // pci enable and watchdog init
  // boot values come from straps; software may override afterwards
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      pci_en_reg <= 1'b0;
      wdt_en_reg <= 1'b0;
    end else if (capture) begin
      pci_en_reg <= is_sat(mode_in);
      wdt_en_reg <= !memory_data_bus_i[boot_cfg_pkg::WDT_DIS_BIT];
    end else if (ctrl_wr) begin
      pci_en_reg <= writedata_i[boot_cfg_pkg::CTRL_PCI_EN_BIT];
      wdt_en_reg <= writedata_i[boot_cfg_pkg::CTRL_WDT_EN_BIT];
    end
  end

  // divide by two
  // a toggle flop gives an exact half rate clock with 50% duty
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      bus_clk_reg <= 1'b0;
    end else begin
      bus_clk_reg <= !bus_clk_reg;
    end
  end

  // avalon handshake: waitrequest drops for exactly one cycle per access
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= !accept;
      if (accept && read_i) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // outputs come straight from flops
  assign readdata_o = rdata_reg;
  assign waitrequest_o = wait_reg;
  assign reset_output_n_o = rst_out_n_reg;
  assign boot_width_16_o = cfg_reg[boot_cfg_pkg::BOOT_WIDTH_BIT];
  assign pci_mode_o = mode_q;
  assign pci_host_o = host_reg;
  assign pci_satellite_o = sat_reg;
  assign pci_enable_o = pci_en_reg;
  assign watchdog_enable_o = wdt_en_reg;
  // pipeline clock select
  // only the capture process writes these bits, so they cannot drift
  assign pclk_select_o =
    cfg_reg[boot_cfg_pkg::PCLK_SEL_MSB:boot_cfg_pkg::PCLK_SEL_LSB];
  assign internal_bus_clock_o = bus_clk_reg;

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_output_n_i);

  // helper: cycles the reset output has stayed low since cold reset
  logic [CNT_W:0] low_cnt_reg;
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      low_cnt_reg <= '0;
    end else if (!rst_out_n_reg) begin
      low_cnt_reg <= low_cnt_reg + (CNT_W+1)'(1);
    end
  end

  sequence s_bus_clk_cycle;
    internal_bus_clock_o ##1 !internal_bus_clock_o ##1 internal_bus_clock_o;
  endsequence

  // the capture edge: straps not yet taken, then taken
  sequence s_boot_done;
    !captured_reg ##1 captured_reg;
  endsequence

  // one answer cycle with waitrequest low, then waitrequest back up
  sequence s_bus_answer;
    !waitrequest_o ##1 waitrequest_o;
  endsequence

  chk_boot_width: assert property (
    $rose(captured_reg) |->
      boot_width_16_o == $past(memory_data_bus_i[boot_cfg_pkg::BOOT_WIDTH_BIT])
  ) else $error("boot width not taken from strap");

  chk_reset_out_len: assert property (
    $rose(reset_output_n_o) |-> low_cnt_reg >= (CNT_W+1)'(RST_OUT_CYCLES)
  ) else $error("reset output released too early");

  chk_reset_out_hold: assert property (
    s_boot_done |-> !reset_output_n_o
  ) else $error("reset output high at strap capture");

  chk_pci_mode_decode: assert property (
    $rose(captured_reg) |-> pci_mode_o == $past(mode_in) &&
      pci_host_o == (pci_mode_o inside {3'h3, 3'h4, 3'h5}) &&
      pci_satellite_o == (pci_mode_o inside {3'h1, 3'h2})
  ) else $error("pci mode decode wrong");

  chk_pci_en_init: assert property (
    $rose(captured_reg) |-> pci_enable_o == (pci_mode_o inside {3'h1, 3'h2})
  ) else $error("pci enable boot value wrong");

  chk_wdt_init: assert property (
    $rose(captured_reg) |->
      watchdog_enable_o == !$past(memory_data_bus_i[boot_cfg_pkg::WDT_DIS_BIT])
  ) else $error("watchdog boot state wrong");

  chk_pclk_frozen: assert property (
    captured_reg && $past(captured_reg) |-> $stable(pclk_select_o)
  ) else $error("pipeline clock select changed");

  chk_bus_clk_half_rate: assert property (
    internal_bus_clock_o |-> s_bus_clk_cycle
  ) else $error("internal bus clock not half rate");

  chk_cfg_hold: assert property (
    captured_reg |=> captured_reg && $stable(cfg_reg) &&
      $stable(pci_host_o) && $stable(pci_satellite_o)
  ) else $error("captured straps changed");

  // reset output checks: once let go it stays up until cold reset
  chk_reset_out_stay: assert property (
    reset_output_n_o |=> reset_output_n_o
  ) else $error("reset output fell without cold reset");

  chk_reset_cnt_done: assert property (
    reset_output_n_o |-> rst_cnt_reg == CNT_W'(RST_OUT_CYCLES)
  ) else $error("reset counter not at its end value");

  // strap decode checks
  chk_pclk_capture: assert property (
    $rose(captured_reg) |-> pclk_select_o == $past(pclk_in)
  ) else $error("pipeline clock select not taken from strap");

  // reserved pci codes must not wake up either side of the interface
  chk_pci_rsvd_mode: assert property (
    $rose(captured_reg) && rsvd_pci |->
      !pci_host_o && !pci_satellite_o && !pci_enable_o
  ) else $error("reserved pci mode treated as active");

  chk_host_sat_excl: assert property (
    captured_reg |-> !(pci_host_o && pci_satellite_o)
  ) else $error("pci host and satellite both set");

  chk_cfg_outputs_hold: assert property (
    captured_reg && $past(captured_reg) |->
      $stable(boot_width_16_o) && $stable(pci_mode_o)
  ) else $error("decoded straps changed after capture");

  chk_bus_clk_phase: assert property (
    $rose(captured_reg) |-> internal_bus_clock_o
  ) else $error("bus clock not started on capture");

  // bus handshake checks: exactly one wait cycle per access
  chk_wait_answer: assert property (
    (read_i || write_i) && waitrequest_o |=> s_bus_answer
  ) else $error("bus request not answered in one cycle");

  chk_wait_idle: assert property (
    !(read_i || write_i) && waitrequest_o |=> waitrequest_o
  ) else $error("waitrequest dropped with no request");

  chk_wait_one_cycle: assert property (
    !waitrequest_o |=> waitrequest_o
  ) else $error("waitrequest low for more than one cycle");

  // read data must stand until the next accepted read
  chk_rdata_hold: assert property (
    !(read_i && waitrequest_o) |=> $stable(readdata_o)
  ) else $error("read data changed without a read");

  // software override of the boot enables
  chk_ctrl_write: assert property (
    ctrl_wr |=>
      pci_enable_o == $past(writedata_i[boot_cfg_pkg::CTRL_PCI_EN_BIT]) &&
      watchdog_enable_o == $past(writedata_i[boot_cfg_pkg::CTRL_WDT_EN_BIT])
  ) else $error("control write not applied");

  chk_ctrl_quiet: assert property (
    captured_reg && !ctrl_wr |=>
      $stable(pci_enable_o) && $stable(watchdog_enable_o)
  ) else $error("enables changed without a control write");

endmodule : boot_config_loader
`default_nettype wire

// >>> boot_strap_model.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_model (
  // clock and cold reset
  input wire logic core_clk_i,
  input wire logic reset_output_n_i,
  // vector the board wants to present
  input wire logic [15:0] strap_i,
  // strap lines into the device
  output logic [15:0] memory_data_bus_o
);
  logic done_reg;
  logic [15:0] churn_reg;

  // straps released after the capture edge, so the lines then wander
  always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
    if (!reset_output_n_i) begin
      done_reg <= 1'b0;
      churn_reg <= 16'h0000;
    end else begin
      done_reg <= 1'b1;
      churn_reg <= churn_reg + 16'h9E37;
    end
  end

  assign memory_data_bus_o = done_reg ? (~strap_i ^ churn_reg)
                                      : {3'h0, strap_i[12:9], 1'b0,
                                         strap_i[7:0]};
endmodule : boot_strap_model
`default_nettype wire

// >>> boot_config_and_clock_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module boot_config_and_clock_setup_tb;
  localparam int RST_N = 8;
  logic core_clk_i = 1'b0;
  logic reset_output_n_i, read_i, write_i;
  logic [15:0] strap_i, memory_data_bus_i, vec;
  logic [3:0] address_i, byteenable_i;
  logic [31:0] writedata_i, readdata_o, seed, rd;
  logic waitrequest_o, reset_output_n_o, boot_width_16_o, pci_host_o;
  logic pci_satellite_o, pci_enable_o, watchdog_enable_o;
  logic internal_bus_clock_o, ibc_exp;
  logic [2:0] pci_mode_o, pclk_select_o;
  logic [1:0] ctrl_exp;
  realtime t_rise, ibc_ns;
  // far-side clock periods, inside the ratio limits
  localparam real CORE_NS = 10.0;
  localparam real ETH_CLK_NS = 40.0;
  localparam real PCI_CLK_NS = 30.0;
  localparam real PCI_MIN_NS = 1000.0 / 66.0;
  int n_errors = 0;
  int num_checks = 0;

  always #5 core_clk_i = ~core_clk_i;

  boot_strap_model boot_strap_model_i (.core_clk_i(core_clk_i),
    .reset_output_n_i(reset_output_n_i), .strap_i(strap_i),
    .memory_data_bus_o(memory_data_bus_i));
  boot_config_loader #(.RST_OUT_CYCLES(RST_N)) boot_config_loader_i (
    .core_clk_i(core_clk_i), .reset_output_n_i(reset_output_n_i),
    .memory_data_bus_i(memory_data_bus_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .reset_output_n_o(reset_output_n_o),
    .boot_width_16_o(boot_width_16_o), .pci_mode_o(pci_mode_o),
    .pci_host_o(pci_host_o), .pci_satellite_o(pci_satellite_o),
    .pci_enable_o(pci_enable_o), .watchdog_enable_o(watchdog_enable_o),
    .pclk_select_o(pclk_select_o),
    .internal_bus_clock_o(internal_bus_clock_o));

  // repeatable stimulus source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // reserved straps are held low by the board, so bit1 stays clear
  function automatic logic [31:0] exp_status(input logic [15:0] v);
    return {28'h0, v[11:10] == 2'b11, v[8], 1'b0, 1'b1};
  endfunction : exp_status

  // one avalon access; request held until waitrequest sampled low
  task automatic bus_op(input logic wr, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk_i);
    address_i <= a;
    read_i <= !wr;
    write_i <= wr;
    writedata_i <= d;
    byteenable_i <= be;
    // no local limit: only the watchdog ends a wait that never answers
    do begin
      @(posedge core_clk_i);
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus_op

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // cut a hang short well beyond the expected run time
  initial begin
    #50000;
    n_errors++;
    $display("BAD t=%0t timeout", $time);
    complete_run();
  end

  initial begin
    {reset_output_n_i, read_i, write_i, address_i, byteenable_i} = '0;
    strap_i = 16'h0000;
    writedata_i = 32'h0;
    seed = 32'h792B1AA1;
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      vec = seed[15:0];
      vec[11:9] = i[2:0];
      if (i == 9) vec = 16'hFFFF;
      vec = vec & 16'h1EFF;
      // cold reset with a fresh strap vector, 6 cycles on the first pass
      reset_output_n_i <= 1'b0;
      strap_i <= vec;
      repeat (i == 0 ? 6 : 2) @(posedge core_clk_i);
      reset_output_n_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      `CHK(boot_width_16_o, vec[7])
      `CHK(pci_mode_o, vec[11:9])
      `CHK(pci_host_o, vec[11:9] >= 3'h3 && vec[11:9] <= 3'h5)
      `CHK(pci_satellite_o, vec[11:9] == 3'h1 || vec[11:9] == 3'h2)
      `CHK(pci_enable_o, vec[11:9] == 3'h1 || vec[11:9] == 3'h2)
      `CHK(watchdog_enable_o, !vec[12])
      `CHK(pclk_select_o, vec[2:0])
      `CHK(reset_output_n_o, 1'b0)
      ibc_exp = 1'b1;
      `CHK(internal_bus_clock_o, ibc_exp)
      for (int k = 1; k <= RST_N; k++) begin
        @(posedge core_clk_i);
        #1;
        ibc_exp = ~ibc_exp;
        `CHK(internal_bus_clock_o, ibc_exp)
        `CHK(reset_output_n_o, k == RST_N)
      end
      // bus clock rate against far-side clocks
      @(posedge internal_bus_clock_o);
      t_rise = $realtime;
      @(posedge internal_bus_clock_o);
      ibc_ns = $realtime - t_rise;
      `CHK(ibc_ns == 2.0 * CORE_NS, 1'b1)
      `CHK(ETH_CLK_NS >= 2.0 * ibc_ns, 1'b1)
      `CHK(PCI_CLK_NS >= ibc_ns / 2.0 && PCI_CLK_NS >= PCI_MIN_NS, 1'b1)
      bus_op(1'b0, boot_cfg_pkg::CFG_OFS, 32'h0, 4'hF, rd);
      `CHK(rd, {16'h0, vec & 16'h1FFF})
      bus_op(1'b0, boot_cfg_pkg::STATUS_OFS, 32'h0, 4'hF, rd);
      `CHK(rd, exp_status(vec))
      ctrl_exp = {!vec[12], vec[11:9] == 3'h1 || vec[11:9] == 3'h2};
      bus_op(1'b0, boot_cfg_pkg::CTRL_OFS, 32'h0, 4'hF, rd);
      `CHK(rd, {30'h0, ctrl_exp})
      seed = xs(seed);
      bus_op(1'b1, boot_cfg_pkg::CTRL_OFS, seed, {3'h7, seed[4]}, rd);
      if (seed[4]) ctrl_exp = seed[1:0];
      bus_op(1'b0, boot_cfg_pkg::CTRL_OFS, 32'h0, 4'hF, rd);
      `CHK(rd, {30'h0, ctrl_exp})
      `CHK(watchdog_enable_o, ctrl_exp[1])
      `CHK(pci_enable_o, ctrl_exp[0])
      bus_op(1'b0, 4'hC, 32'h0, 4'hF, rd);
      `CHK(rd, 32'h0)
      `CHK(pci_mode_o, vec[11:9])
      `CHK(pclk_select_o, vec[2:0])
      $display("test %0d mode %0d done", i, vec[11:9]);
    end
    complete_run();
  end
endmodule : boot_config_and_clock_setup_tb
`default_nettype wire
